/* include/i2c_fsel_regs.svh */
// Constants for the I2C function-select slave front end
`ifndef I2C_FSEL_REGS_SVH
`define I2C_FSEL_REGS_SVH
`define FSEL_MEM_CODE     4'ha
`define FSEL_CLK_CODE     4'hd
`define FSEL_CTL_CODE     4'h3
`define HS_MASTER_CODE    5'h01
`define MEM_ADDR_W        13
`define MEM_LAST_ADDR     13'h1fff
`define CLK_LAST_ADDR     8'h0f
`define CTL_LAST_ADDR     8'h0c
`define CTL_CMD_ADDR      8'haa
`define BUS_FREE_SDA      1'b1
`endif

/* include/i2c_fsel_pkg.sv */
// Types shared by the I2C function-select slave
package i2c_fsel_pkg;
   typedef enum logic [1:0] {
      FUNC_NONE,
      FUNC_MEM,
      FUNC_CLK,
      FUNC_CTL
   } func_e;

   typedef enum {
      ST_IDLE,
      ST_SLV_ADDR,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_WR_DATA,
      ST_RD_DATA,
      ST_IGNORE
   } phase_e;

   // Request towards the selected function
   typedef struct packed {
      func_e       func;
      logic [12:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } func_req_s;
endpackage : i2c_fsel_pkg

/* hw/i2c_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
module i2c_pin_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Pins and filtered levels
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one");
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_reg, s2_reg, s3_reg, lvl_reg;
         logic lvl_next;
         // Level changes only once stages two and three agree
         always_comb begin
            lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
         end
         // Reset to idle-high, the released open-drain state
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_reg  <= 1'b1;
               s2_reg  <= 1'b1;
               s3_reg  <= 1'b1;
               lvl_reg <= 1'b1;
            end else begin
               s1_reg  <= pin[g];
               s2_reg  <= s1_reg;
               s3_reg  <= s2_reg;
               lvl_reg <= lvl_next;
            end
         end
         assign level[g] = lvl_reg;
      end
   endgenerate
endmodule : i2c_pin_sync

/* hw/i2c_fsel_slave.sv */
// I2C slave front end with function select for memory, clock and control registers
//
// Overview of operation
// - Only 7-bit slave addressing is decoded; 10-bit prefixes never match.
// - First byte after START is slave address plus direction; one reads.
// - Receiver acknowledges each byte by pulling SDA low on ninth pulse.
// - Address advances after every data byte, at the eighth falling SCL edge.
// - Address wraps to zero past the last location; writes continue.
// - Write: address bytes then data bytes, all acknowledged, until STOP/Sr.
// - Read without address starts at the current function pointer.
// - Address-only write sets the pointer and stores no data.
// - Master NACK ends a read; device releases SDA.
// - SDA changes only while SCL is low, except START and STOP.
// - START is SDA falling while SCL is high.
// - STOP is SDA rising while SCL is high; ends the transaction.
// - Bus busy from START until STOP.
// - Repeated START abandons transfer, bus stays busy, new address awaited.
// - Address mismatch: ignore the bus until STOP or repeated START.
// - Bytes are eight bits, MSB first, each followed by acknowledge slot.
// - Transmitter releases SDA after each byte; NACK aborts the operation.
// - Write bytes to protected locations are not acknowledged.
// - START, master code 00001xxx and NACK enter high-speed mode.
// - High-speed mode survives repeated START, ends on STOP.
// - Address bits 7:4 select memory, clock or control; 3:1 device select.
// - Memory 8K bytes, clock 16 bytes, control 14 bytes incl command.
// - Device select bits compare with the three strap pins.
// - Memory takes two address bytes; top three bits ignored.
// - Clock and control functions take one register address byte.
`timescale 1ns/100ps
`include "i2c_fsel_regs.svh"
module i2c_fsel_slave (
   // Clock and reset
   input  wire logic                  CLK_SYS,
   input  wire logic                  RSTN,
   // I2C pins, open drain
   input  wire logic                  SCL_I,
   input  wire logic                  SDA_I,
   output logic                       SDA_O,
   output logic                       SDA_OE,
   // Straps and write protect
   input  wire logic [2:0]            DEVICE_SELECT_STRAPS,
   input  wire logic                  WRITE_PROTECT,
   // Function access
   output i2c_fsel_pkg::func_req_s    FUNC_REQ,
   input  wire logic [7:0]            FUNC_RDATA,
   // Status
   output logic                       BUS_BUSY,
   output logic                       HIGH_SPEED_TRANSFER_STATE
);
   logic [4:0] lvl;
   logic       scl_reg, sda_reg;
   logic       scl, sda;

   // Pin filtering; bus lines and straps all come from outside the clock domain
   i2c_pin_sync #(.WIDTH(5)) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RSTN),
      .pin   ({SCL_I, SDA_I, DEVICE_SELECT_STRAPS}),
      .level (lvl)
   );
   assign scl = lvl[4];
   assign sda = lvl[3];

   // Edge and condition detection from filtered levels
   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise   = scl & ~scl_reg;
   assign scl_fall   = ~scl & scl_reg;
   assign start_cond = scl & scl_reg & sda_reg & ~sda;
   assign stop_cond  = scl & scl_reg & ~sda_reg & sda;

   // Protocol state
   i2c_fsel_pkg::phase_e phase_reg, phase_next;
   i2c_fsel_pkg::func_e  func_reg, func_next;
   logic [3:0]  bit_reg, bit_next;
   logic [7:0]  sh_reg, sh_next;
   logic        rw_reg, rw_next;
   logic        busy_reg, busy_next;
   logic        hs_reg, hs_next;
   logic        first_reg, first_next;
   logic        ack_reg, ack_next;
   logic        drv_reg, drv_next;
   logic [7:0]  tx_reg, tx_next;
   logic [4:0]  ahi_reg, ahi_next;
   logic [12:0] mem_ptr_reg, mem_ptr_next;
   logic [7:0]  clk_ptr_reg, clk_ptr_next;
   logic [7:0]  ctl_ptr_reg, ctl_ptr_next;
   logic        edge_reg, edge_next;
   i2c_fsel_pkg::func_req_s req_reg, req_next;
   logic                dev_match_reg;
   i2c_fsel_pkg::func_e func_sel_reg;
   logic [12:0]         cur_ptr_sel, cur_ptr_inc;

   // Current pointer of the addressed function
   logic [12:0] cur_ptr;
   always_comb begin
      unique case (func_reg)
         i2c_fsel_pkg::FUNC_MEM: cur_ptr = mem_ptr_reg;
         i2c_fsel_pkg::FUNC_CLK: cur_ptr = {5'h00, clk_ptr_reg};
         i2c_fsel_pkg::FUNC_CTL: cur_ptr = {5'h00, ctl_ptr_reg};
         i2c_fsel_pkg::FUNC_NONE: cur_ptr = 13'h0000;
      endcase
   end

   // Protected write check; the function side decodes the block levels into WRITE_PROTECT
   logic wr_denied;
   assign wr_denied = WRITE_PROTECT && (func_reg == i2c_fsel_pkg::FUNC_MEM);

   // Pointer advance with wrap per function
   function automatic logic [7:0] reg_inc(input logic [7:0] p, input logic [7:0] last);
      reg_inc = (p == last) ? 8'h00 : p + 8'h01;
   endfunction : reg_inc

   // Decoded slave address byte (sh_next full at bit 8)
   logic [7:0] rx_byte;
   logic       dev_match;
   i2c_fsel_pkg::func_e byte_func;
   always_comb begin
      rx_byte   = {sh_reg[6:0], sda};
      dev_match = (rx_byte[3:1] == lvl[2:0]);
      unique case (rx_byte[7:4])
         `FSEL_MEM_CODE: byte_func = i2c_fsel_pkg::FUNC_MEM;
         `FSEL_CLK_CODE: byte_func = i2c_fsel_pkg::FUNC_CLK;
         `FSEL_CTL_CODE: byte_func = i2c_fsel_pkg::FUNC_CTL;
         default:        byte_func = i2c_fsel_pkg::FUNC_NONE; // 10-bit prefix 11110 lands here
      endcase
   end

   // Next-state logic for the whole protocol engine
   always_comb begin
      phase_next   = phase_reg;
      func_next    = func_reg;
      bit_next     = bit_reg;
      sh_next      = sh_reg;
      rw_next      = rw_reg;
      busy_next    = busy_reg;
      hs_next      = hs_reg;
      first_next   = first_reg;
      ack_next     = ack_reg;
      drv_next     = drv_reg;
      tx_next      = tx_reg;
      ahi_next     = ahi_reg;
      mem_ptr_next = mem_ptr_reg;
      clk_ptr_next = clk_ptr_reg;
      ctl_ptr_next = ctl_ptr_reg;
      edge_next    = 1'b0;
      req_next     = req_reg;
      req_next.wr  = 1'b0;
      req_next.rd  = 1'b0;
      if (stop_cond) begin
         // Ends everything and leaves high speed
         phase_next = i2c_fsel_pkg::ST_IDLE;
         busy_next  = 1'b0;
         hs_next    = 1'b0;
         drv_next   = 1'b0;
      end else if (start_cond) begin
         // Fresh or repeated START; high speed kept across Sr
         phase_next = i2c_fsel_pkg::ST_SLV_ADDR;
         busy_next  = 1'b1;
         bit_next   = 4'h0;
         first_next = ~busy_reg;
         drv_next   = 1'b0;
      end else if (scl_rise && phase_reg != i2c_fsel_pkg::ST_IDLE && phase_reg != i2c_fsel_pkg::ST_IGNORE) begin
         // Data sampled on rising SCL, MSB first
         if (bit_reg < 4'h8) begin
            sh_next = rx_byte;
         end else if (phase_reg == i2c_fsel_pkg::ST_RD_DATA && sda) begin
            phase_next = i2c_fsel_pkg::ST_IGNORE; // master NACK
         end
         bit_next = bit_reg + 4'h1;
      end else if (scl_fall && phase_reg != i2c_fsel_pkg::ST_IDLE && phase_reg != i2c_fsel_pkg::ST_IGNORE) begin
         // SDA driven only after SCL falls
         drv_next = 1'b0;
         if (bit_reg == 4'h8) begin
            // Eighth bit just sampled: act on the byte and set the acknowledge slot
            ack_next = 1'b0;
            unique case (phase_reg)
               i2c_fsel_pkg::ST_SLV_ADDR: begin
                  if (first_reg && sh_reg[7:3] == `HS_MASTER_CODE) begin
                     hs_next    = 1'b1; // NACK left to the bus
                     phase_next = i2c_fsel_pkg::ST_IGNORE;
                  end else if (dev_match_reg && func_sel_reg != i2c_fsel_pkg::FUNC_NONE) begin
                     func_next = func_sel_reg;
                     rw_next   = sh_reg[0];
                     ack_next  = 1'b1;
                     if (sh_reg[0]) begin
                        phase_next = i2c_fsel_pkg::ST_RD_DATA;
                     end else if (func_sel_reg == i2c_fsel_pkg::FUNC_MEM) begin
                        phase_next = i2c_fsel_pkg::ST_ADDR_HI;
                     end else begin
                        phase_next = i2c_fsel_pkg::ST_ADDR_LO;
                     end
                  end else begin
                     phase_next = i2c_fsel_pkg::ST_IGNORE;
                  end
               end
               i2c_fsel_pkg::ST_ADDR_HI: begin
                  ahi_next   = sh_reg[4:0]; // top three bits dropped
                  ack_next   = 1'b1;
                  phase_next = i2c_fsel_pkg::ST_ADDR_LO;
               end
               i2c_fsel_pkg::ST_ADDR_LO: begin
                  // Pointer loaded, no data stored yet
                  unique case (func_reg)
                     i2c_fsel_pkg::FUNC_MEM: mem_ptr_next = {ahi_reg, sh_reg};
                     i2c_fsel_pkg::FUNC_CLK: clk_ptr_next = sh_reg;
                     i2c_fsel_pkg::FUNC_CTL: ctl_ptr_next = sh_reg;
                     i2c_fsel_pkg::FUNC_NONE: ;
                  endcase
                  ack_next   = 1'b1;
                  phase_next = i2c_fsel_pkg::ST_WR_DATA;
               end
               i2c_fsel_pkg::ST_WR_DATA: begin
                  if (!wr_denied) begin
                     req_next.func  = func_reg;
                     req_next.addr  = cur_ptr;
                     req_next.wdata = sh_reg;
                     req_next.wr    = 1'b1;
                     ack_next       = 1'b1;
                     edge_next      = 1'b1;
                  end else begin
                     phase_next = i2c_fsel_pkg::ST_IGNORE;
                  end
               end
               i2c_fsel_pkg::ST_RD_DATA: begin
                  edge_next = 1'b1; // byte sent, advance pointer
               end
               default: ;
            endcase
            drv_next = ack_next;
         end else if (bit_reg == 4'h9) begin
            // Acknowledge slot over; release and start next byte
            bit_next = 4'h0;
            if (phase_reg == i2c_fsel_pkg::ST_RD_DATA) begin
               tx_next  = FUNC_RDATA;
               drv_next = ~FUNC_RDATA[7];
            end
         end else if (phase_reg == i2c_fsel_pkg::ST_RD_DATA) begin
            tx_next  = {tx_reg[6:0], 1'b1};
            drv_next = ~tx_reg[6];
         end
      end
      // Read fetch for the first read byte, as the read slave address byte is accepted
      if (phase_next == i2c_fsel_pkg::ST_RD_DATA && phase_reg == i2c_fsel_pkg::ST_SLV_ADDR) begin
         req_next.func = func_next;
         req_next.addr = cur_ptr_sel;
         req_next.rd   = 1'b1;
      end
      // Advance pointers; new address ready before the acknowledge
      if (edge_reg) begin
         unique case (func_reg)
            i2c_fsel_pkg::FUNC_MEM: mem_ptr_next = mem_ptr_reg + 13'h0001;       // wraps
            i2c_fsel_pkg::FUNC_CLK: clk_ptr_next = reg_inc(clk_ptr_reg, `CLK_LAST_ADDR);
            i2c_fsel_pkg::FUNC_CTL: ctl_ptr_next = (ctl_ptr_reg == `CTL_LAST_ADDR) ? `CTL_CMD_ADDR :
                                                   reg_inc(ctl_ptr_reg, `CTL_CMD_ADDR);
            i2c_fsel_pkg::FUNC_NONE: ;
         endcase
         if (rw_reg) begin
            req_next.addr = cur_ptr_inc;
            req_next.rd   = 1'b1;
         end
      end
   end

   // Pointer of the function being addressed, and of the current one after its advance
   always_comb begin
      unique case (func_sel_reg)
         i2c_fsel_pkg::FUNC_MEM: cur_ptr_sel = mem_ptr_reg;
         i2c_fsel_pkg::FUNC_CLK: cur_ptr_sel = {5'h00, clk_ptr_reg};
         i2c_fsel_pkg::FUNC_CTL: cur_ptr_sel = {5'h00, ctl_ptr_reg};
         i2c_fsel_pkg::FUNC_NONE: cur_ptr_sel = 13'h0000;
      endcase
      unique case (func_reg)
         i2c_fsel_pkg::FUNC_MEM: cur_ptr_inc = mem_ptr_next;
         i2c_fsel_pkg::FUNC_CLK: cur_ptr_inc = {5'h00, clk_ptr_next};
         i2c_fsel_pkg::FUNC_CTL: cur_ptr_inc = {5'h00, ctl_ptr_next};
         i2c_fsel_pkg::FUNC_NONE: cur_ptr_inc = 13'h0000;
      endcase
   end

   // Register stage; pointers reset to zero, lines idle released
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         scl_reg       <= 1'b1;
         sda_reg       <= 1'b1;
         phase_reg     <= i2c_fsel_pkg::ST_IDLE;
         func_reg      <= i2c_fsel_pkg::FUNC_NONE;
         bit_reg       <= 4'h0;
         sh_reg        <= 8'h00;
         rw_reg        <= 1'b0;
         busy_reg      <= 1'b0;
         hs_reg        <= 1'b0;
         first_reg     <= 1'b0;
         ack_reg       <= 1'b0;
         drv_reg       <= 1'b0;
         tx_reg        <= 8'hff;
         ahi_reg       <= 5'h00;
         mem_ptr_reg   <= 13'h0000;
         clk_ptr_reg   <= 8'h00;
         ctl_ptr_reg   <= 8'h00;
         edge_reg      <= 1'b0;
         req_reg       <= '0;
         dev_match_reg <= 1'b0;
         func_sel_reg  <= i2c_fsel_pkg::FUNC_NONE;
      end else begin
         scl_reg       <= scl;
         sda_reg       <= sda;
         phase_reg     <= phase_next;
         func_reg      <= func_next;
         bit_reg       <= bit_next;
         sh_reg        <= sh_next;
         rw_reg        <= rw_next;
         busy_reg      <= busy_next;
         hs_reg        <= hs_next;
         first_reg     <= first_next;
         ack_reg       <= ack_next;
         drv_reg       <= drv_next;
         tx_reg        <= tx_next;
         ahi_reg       <= ahi_next;
         mem_ptr_reg   <= mem_ptr_next;
         clk_ptr_reg   <= clk_ptr_next;
         ctl_ptr_reg   <= ctl_ptr_next;
         edge_reg      <= edge_next;
         req_reg       <= req_next;
         if (scl_rise && bit_reg == 4'h7) begin
            dev_match_reg <= dev_match;
            func_sel_reg  <= byte_func;
         end
      end
   end

   // Open drain: only ever pull low
   assign SDA_O  = 1'b0;
   assign SDA_OE = drv_reg;
   assign FUNC_REQ = req_reg;
   assign BUS_BUSY = busy_reg;
   assign HIGH_SPEED_TRANSFER_STATE = hs_reg;
endmodule : i2c_fsel_slave

/* bench/i2c_fsel_slave_chk.sv */
// Concurrent checks on the ports of the function-select slave
`timescale 1ns/100ps
module i2c_fsel_slave_chk (
   // Clock and reset
   input  wire logic                CLK_SYS,
   input  wire logic                RSTN,
   // Bus pins
   input  wire logic                SCL_I,
   input  wire logic                SDA_I,
   input  wire logic                SDA_O,
   input  wire logic                SDA_OE,
   // Straps, protect and function side
   input  wire logic [2:0]          DEVICE_SELECT_STRAPS,
   input  wire logic                WRITE_PROTECT,
   input  i2c_fsel_pkg::func_req_s  FUNC_REQ,
   input  wire logic [7:0]          FUNC_RDATA,
   // Status
   input  wire logic                BUS_BUSY,
   input  wire logic                HIGH_SPEED_TRANSFER_STATE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);

   // Bus conditions on the raw pins; design sees them a few clocks later
   sequence s_start;
      SCL_I && $fell(SDA_I);
   endsequence
   sequence s_stop;
      SCL_I && $rose(SDA_I);
   endsequence

   AST_BUSY_SET: assert property (s_start |-> ##[1:10] BUS_BUSY)
      else $error("busy not raised after start");
   AST_BUSY_FREE: assert property (s_stop ##0 BUS_BUSY |-> ##[1:10] !BUS_BUSY)
      else $error("busy not dropped after stop");
   AST_HS_KEEP: assert property (HIGH_SPEED_TRANSFER_STATE ##0 s_start |=> HIGH_SPEED_TRANSFER_STATE [*8])
      else $error("high speed lost on repeated start");
   AST_HS_OFF: assert property (s_stop |-> ##[1:10] !HIGH_SPEED_TRANSFER_STATE)
      else $error("high speed kept after stop");
   AST_OE_STEADY: assert property ($rose(SCL_I) |=> $stable(SDA_OE) [*8])
      else $error("data pin moved while clock high");
   AST_OE_IDLE: assert property (!BUS_BUSY && !$past(BUS_BUSY) |-> !SDA_OE)
      else $error("pin pulled on a free bus");
   AST_PULL_LOW: assert property (SDA_OE |-> !SDA_O)
      else $error("driven level is not low");
   AST_WR_PULSE: assert property (FUNC_REQ.wr |=> !FUNC_REQ.wr)
      else $error("write request longer than one clock");
   AST_RD_WR_EXCL: assert property (!(FUNC_REQ.wr && FUNC_REQ.rd))
      else $error("read and write requested together");
   AST_WP_MEM: assert property (FUNC_REQ.wr && FUNC_REQ.func == i2c_fsel_pkg::FUNC_MEM |-> !WRITE_PROTECT)
      else $error("memory written while protected");
   AST_CLK_RANGE: assert property (FUNC_REQ.wr && FUNC_REQ.func == i2c_fsel_pkg::FUNC_CLK
      |-> FUNC_REQ.addr <= 13'h000f)
      else $error("clock register address out of range");
   AST_CTL_RANGE: assert property (FUNC_REQ.wr && FUNC_REQ.func == i2c_fsel_pkg::FUNC_CTL
      |-> FUNC_REQ.addr <= 13'h000c || FUNC_REQ.addr == 13'h00aa)
      else $error("control address out of range");
   AST_REQ_FUNC: assert property (FUNC_REQ.wr || FUNC_REQ.rd |-> FUNC_REQ.func != i2c_fsel_pkg::FUNC_NONE)
      else $error("request without a function");
   AST_WR_BUSY: assert property (FUNC_REQ.wr |-> BUS_BUSY)
      else $error("write outside a transaction");
endmodule : i2c_fsel_slave_chk

bind i2c_fsel_slave i2c_fsel_slave_chk i_chk (
   .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .DEVICE_SELECT_STRAPS(DEVICE_SELECT_STRAPS), .WRITE_PROTECT(WRITE_PROTECT), .FUNC_REQ(FUNC_REQ),
   .FUNC_RDATA(FUNC_RDATA), .BUS_BUSY(BUS_BUSY), .HIGH_SPEED_TRANSFER_STATE(HIGH_SPEED_TRANSFER_STATE)
);

/* bench/i2c_bus_master_model.sv */
// Behavioural I2C bus master: drives SCL, pulls SDA low when asked
`timescale 1ns/100ps
module i2c_bus_master_model (
   // Clock
   input  wire logic clk,
   // Bus lines
   input  wire logic sda,
   output logic      scl,
   output logic      pull
);
   // Quarter bit in system clocks; must stay above the pin filter delay
   int quarter = 10;

   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end

   task automatic hp();
      repeat (quarter) @(negedge clk);
   endtask : hp

   // Start or repeated start; SCL idles high between frames
   task automatic start();
      pull = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      pull = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask : start

   task automatic stop();
      pull = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      pull = 1'b0;
      hp();
   endtask : stop

   // Data set only in the low phase, sampled mid high phase
   task automatic xbit(input logic b, output logic r);
      pull = ~b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      hp();
      scl = 1'b0;
      hp();
   endtask : xbit

   // Eight bits MSB first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(~ack_in, r);
      ack = ~r;
   endtask : xbyte
endmodule : i2c_bus_master_model

/* bench/tb_i2c_fsel_slave.sv */
// Self-checking bench for the I2C function-select slave
`timescale 1ns/100ps
`include "i2c_fsel_regs.svh"
module tb_i2c_fsel_slave;
   localparam logic [2:0] sv = 3'h5;
   localparam logic [7:0] mw = {`FSEL_MEM_CODE, sv, 1'b0};
   localparam logic [7:0] mr = {`FSEL_MEM_CODE, sv, 1'b1};
   logic                    clk = 1'b0;
   logic                    rstn = 1'b0;
   logic                    wp = 1'b0;
   logic [7:0]              rdata = 8'h00;
   logic                    scl, pull, sda, sda_o, sda_oe, busy, hs;
   i2c_fsel_pkg::func_req_s req;
   i2c_fsel_pkg::func_req_s wq[$];
   int                      miscompares = 0;
   int                      num_checks = 0;

   always #25 clk = ~clk;
   // Open-drain wire with pull-up
   assign sda = ~(pull | (sda_oe & ~sda_o));

   i2c_bus_master_model i_master (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
   i2c_fsel_slave i_dut (
      .CLK_SYS(clk), .RSTN(rstn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .DEVICE_SELECT_STRAPS(sv), .WRITE_PROTECT(wp), .FUNC_REQ(req), .FUNC_RDATA(rdata),
      .BUS_BUSY(busy), .HIGH_SPEED_TRANSFER_STATE(hs)
   );

   // Function side: read data follows the address, writes are logged
   always @(negedge clk) begin
      if (req.rd === 1'b1) rdata <= req.addr[7:0] ^ 8'h5a;
      if (req.wr === 1'b1) wq.push_back(req);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wb(input logic [7:0] d, input logic exp_ack);
      logic [7:0] q;
      logic       a;
      i_master.xbyte(d, 1'b0, q, a);
      chk(a, exp_ack);
   endtask : wb

   // Master acks every byte but the last
   task automatic rb(input logic [7:0] exp, input logic ack_in);
      logic [7:0] q;
      logic       a;
      i_master.xbyte(8'hff, ack_in, q, a);
      chk(q, exp);
      chk(a, ack_in);
   endtask : rb

   task automatic chkw(input i2c_fsel_pkg::func_e f, input logic [12:0] a, input logic [7:0] d);
      i2c_fsel_pkg::func_req_s e;
      if (wq.size() == 0) begin
         chk(1'b0, 1'b1);
      end else begin
         e = wq.pop_front();
         chk({e.func, e.addr, e.wdata}, {f, a, d});
      end
   endtask : chkw

   task automatic t_burst_write();
      i_master.start();
      chk(busy, 1'b1);
      wb(mw, 1'b1);
      wb(8'hff, 1'b1);
      wb(8'hfe, 1'b1);
      for (int i = 0; i < 3; i++) wb(8'(8'h30 + i), 1'b1);
      i_master.stop();
      chk(busy, 1'b0);
      chkw(i2c_fsel_pkg::FUNC_MEM, 13'h1ffe, 8'h30);
      chkw(i2c_fsel_pkg::FUNC_MEM, 13'h1fff, 8'h31);
      chkw(i2c_fsel_pkg::FUNC_MEM, 13'h0000, 8'h32);
   endtask : t_burst_write

   task automatic t_random_read();
      i_master.start();
      wb(mw, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h10, 1'b1);
      i_master.start();
      wb(mr, 1'b1);
      rb(8'h10 ^ 8'h5a, 1'b1);
      rb(8'h11 ^ 8'h5a, 1'b0);
      chk(sda_oe, 1'b0);
      i_master.stop();
      chk(wq.size(), 0);
   endtask : t_random_read

   // Clock pointer wraps at 0x0f, control skips to the command byte
   task automatic t_functions();
      i_master.start();
      wb({`FSEL_CLK_CODE, sv, 1'b0}, 1'b1);
      wb(8'h0f, 1'b1);
      wb(8'h11, 1'b1);
      wb(8'h12, 1'b1);
      i_master.start();
      wb({`FSEL_CTL_CODE, sv, 1'b0}, 1'b1);
      for (int i = 0; i < 4; i++) wb(8'h0c + 8'(i * 21), 1'b1);
      i_master.stop();
      chkw(i2c_fsel_pkg::FUNC_CLK, 13'h000f, 8'h11);
      chkw(i2c_fsel_pkg::FUNC_CLK, 13'h0000, 8'h12);
      chkw(i2c_fsel_pkg::FUNC_CTL, 13'h000c, 8'h21);
      chkw(i2c_fsel_pkg::FUNC_CTL, 13'h00aa, 8'h36);
      chkw(i2c_fsel_pkg::FUNC_CTL, 13'h0000, 8'h4b);
   endtask : t_functions

   // Clock read from its own pointer, then memory pointer untouched by register traffic
   task automatic t_current_read();
      i_master.start();
      wb({`FSEL_CLK_CODE, sv, 1'b1}, 1'b1);
      rb(8'h01 ^ 8'h5a, 1'b0);
      i_master.start();
      wb(mr, 1'b1);
      rb(8'h12 ^ 8'h5a, 1'b0);
      i_master.stop();
   endtask : t_current_read

   task automatic t_high_speed();
      i_master.start();
      wb(8'h09, 1'b0);
      chk(hs, 1'b1);
      i_master.quarter = 8;
      i_master.start();
      wb(mw, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h40, 1'b1);
      wb(8'h77, 1'b1);
      i_master.start();
      chk({busy, hs}, 2'b11);
      wb(mr, 1'b1);
      rb(8'h41 ^ 8'h5a, 1'b0);
      i_master.stop();
      chk(hs, 1'b0);
      i_master.quarter = 10;
      chkw(i2c_fsel_pkg::FUNC_MEM, 13'h0040, 8'h77);
   endtask : t_high_speed

   task automatic t_write_protect();
      wp = 1'b1;
      i_master.start();
      wb(mw, 1'b1);
      wb(8'h01, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h99, 1'b0);
      i_master.stop();
      wp = 1'b0;
      chk(wq.size(), 0);
   endtask : t_write_protect

   // Wrong straps, ten-bit prefix, unknown code, general call
   task automatic t_reject();
      logic [7:0] bad [4];
      bad = '{{`FSEL_MEM_CODE, ~sv, 1'b0}, 8'hf0, {4'h5, sv, 1'b0}, 8'h00};
      for (int i = 0; i < 4; i++) begin
         i_master.start();
         wb(bad[i], 1'b0);
         wb(8'h55, 1'b0);
         i_master.stop();
      end
      chk(wq.size(), 0);
   endtask : t_reject

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // Watchdog: the sequence needs roughly 16300 clocks
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      finish_test();
   end

   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      t_burst_write();
      t_random_read();
      t_functions();
      t_current_read();
      t_high_speed();
      t_write_protect();
      t_reject();
      finish_test();
   end
endmodule : tb_i2c_fsel_slave
